// >>> verilog/dmars_pkg.sv
// DMA request select and last-channel status: shared constants and types.
// Assumes one system clock, AHB-Lite register access, NCH identical channels.
//
// What this block does
// - Force bit triggers exactly one transfer
// - Force clear: selected request starts transfers
// - Writing zero to force does nothing
// - Force clears on completion or channel disable
// - Eight-bit field picks the request line
// - Last channel resets to 1111, none yet
// - Last channel holds most recent channel number
package dmars_pkg;

   // ----------------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------------
   localparam int unsigned NCH  = 4;          // Channels implemented
   localparam int unsigned NREQ = 256;        // Request lines, one per select code

   // ----------------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------------
   localparam logic [7:0] OFF_CH_BASE   = 8'h00;  // First channel block
   localparam logic [7:0] OFF_CH_STRIDE = 8'h08;  // Channel block spacing
   localparam logic [7:0] OFF_REQSEL    = 8'h00;  // Request select within block
   localparam logic [7:0] OFF_CTRL      = 8'h04;  // Channel enable within block
   localparam logic [7:0] OFF_LAST      = 8'h20;  // Last channel status
   localparam logic [7:0] OFF_BUSY      = 8'h24;  // Transfer request status

   // ----------------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------------
   localparam int unsigned FORCE_BIT = 15;
   localparam int unsigned EN_BIT    = 0;
   localparam logic [7:0]  SEL_RST   = 8'h00;
   localparam logic [3:0]  LAST_RST  = 4'hf;   // No transfer since reset
   localparam logic        READY_RST = 1'b1;
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0]  HSIZE_WORD    = 3'h2;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      DMARS_IDLE   = 2'h0,
      DMARS_AUTO   = 2'h1,
      DMARS_MANUAL = 2'h2
   } dmars_chst_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] addr;
   } dmars_wr_t;

   typedef struct packed {
      dmars_chst_t st;
      logic        force_q;
      logic        prev;
      logic        pending;
   } dmars_chan_t;

   typedef struct packed {
      logic [NCH-1:0][7:0] sel;
      logic [NCH-1:0]      en;
      logic [3:0]          last;
      dmars_wr_t           wr;
      logic [31:0]         rdata;
      logic                ready;
   } dmars_top_t;

endpackage : dmars_pkg

// >>> verilog/dmars_chan.sv
// One DMA channel: request selection, manual force and transfer handshake.
// Assumes xfer_done is a one-cycle pulse from the transfer engine.
`timescale 1ns/1ps

module dmars_chan import dmars_pkg::*; (
   input  wire logic            clk,
   input  wire logic            rst_n,
   input  wire logic            enable,
   input  wire logic            force_set,
   input  wire logic [7:0]      src_sel,
   input  wire logic [NREQ-1:0] req_lines,
   input  wire logic            xfer_done,
   output logic                 force_q,
   output logic                 busy
);

   dmars_chan_t s_q;
   dmars_chan_t s_d;
   logic        sel_req;
   logic        edge_det;

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      s_d      = s_q;
      sel_req  = req_lines[src_sel];
      edge_det = sel_req & ~s_q.prev;
      s_d.prev = sel_req;
      if (force_set) begin
         s_d.force_q = 1'b1;                         // Only software sets it
      end
      if (edge_det) begin
         s_d.pending = 1'b1;
      end
      unique case (s_q.st)
         DMARS_IDLE: begin
            if (enable && s_q.force_q) begin
               s_d.st = DMARS_MANUAL;
            end else if (enable && (s_q.pending || edge_det)) begin
               s_d.st      = DMARS_AUTO;
               s_d.pending = 1'b0;
            end
         end
         DMARS_AUTO: begin
            if (xfer_done) begin
               s_d.st = DMARS_IDLE;
            end
         end
         DMARS_MANUAL: begin
            if (xfer_done) begin
               s_d.st = DMARS_IDLE;
               if (!force_set) begin
                  s_d.force_q = 1'b0;
               end
            end
         end
         default: s_d.st = DMARS_IDLE;
      endcase
      // Disabled channel drops activity, force and pending request
      if (!enable) begin
         s_d.st      = DMARS_IDLE;
         s_d.force_q = 1'b0;
         s_d.pending = 1'b0;
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '{st: DMARS_IDLE, force_q: 1'b0, prev: 1'b0, pending: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign force_q = s_q.force_q;
   assign busy    = (s_q.st != DMARS_IDLE);

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_force_idle;
      s_q.st == DMARS_IDLE && enable && s_q.force_q;
   endsequence

   sequence s_manual_end;
      s_q.st == DMARS_MANUAL && xfer_done && enable && !force_set;
   endsequence

   AST_FORCE_START: assert property (s_force_idle |=> s_q.st == DMARS_MANUAL)
      else $error("forced channel did not start");
   AST_FORCE_ONCE: assert property (s_manual_end |=> !s_q.force_q ##1 s_q.st != DMARS_MANUAL)
      else $error("forced transfer repeated or force kept");
   AST_AUTO_START: assert property (s_q.st == DMARS_IDLE && enable && !s_q.force_q && edge_det
                                    |=> s_q.st == DMARS_AUTO)
      else $error("selected request did not start transfer");
   AST_NO_SW_CLEAR: assert property (s_q.force_q && enable && !(s_q.st == DMARS_MANUAL && xfer_done)
                                     |=> s_q.force_q)
      else $error("force cleared without completion");
   AST_DIS_CLEAR: assert property (!enable |=> !s_q.force_q && s_q.st == DMARS_IDLE)
      else $error("disabled channel kept force or activity");

endmodule : dmars_chan

// >>> verilog/dmars_top.sv
// DMA request select and last-channel status with an AHB-Lite register slave.
// Assumes a single AHB-Lite master, word transfers, and a transfer engine
// that answers each xfer_req with a one-cycle xfer_done pulse.
`timescale 1ns/1ps

module dmars_top import dmars_pkg::*; (
   input  wire logic            clk,
   input  wire logic            resetn,
   input  wire logic            hsel,
   input  wire logic [31:0]     haddr,
   input  wire logic [1:0]      htrans,
   input  wire logic            hwrite,
   input  wire logic [2:0]      hsize,
   input  wire logic            hready,
   input  wire logic [31:0]     hwdata,
   output logic                 hreadyout,
   output logic                 hresp,
   output logic [31:0]          hrdata,
   input  wire logic [NREQ-1:0] req_lines,
   input  wire logic [NCH-1:0]  xfer_done,
   output logic [NCH-1:0]       xfer_req
);

   // ----------------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------------
   logic [1:0] rsync_q;
   logic       rst_n;

   // Asynchronous assert, two-stage synchronous release
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rsync_q <= 2'h0;
      end else begin
         rsync_q <= {rsync_q[0], 1'b1};
      end
   end

   assign rst_n = rsync_q[1];

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   dmars_top_t     r_q;
   dmars_top_t     r_d;
   logic [NCH-1:0] force_set;
   logic [NCH-1:0] force_st;
   logic [NCH-1:0] busy;
   logic           accept;
   logic           any_done;
   logic [3:0]     win;

   // Byte address of a register inside a channel block
   function automatic logic [7:0] ch_addr(input int unsigned ch, input logic [7:0] off);
      ch_addr = 8'(OFF_CH_BASE + OFF_CH_STRIDE * 8'(ch) + off);
   endfunction : ch_addr

   // ----------------------------------------------------------------------
   // Completion tracking
   // ----------------------------------------------------------------------
   // Highest numbered channel wins when several finish together
   always_comb begin
      any_done = 1'b0;
      win      = LAST_RST;
      for (int unsigned ch = 0; ch < NCH; ch++) begin
         if (xfer_done[ch] && busy[ch]) begin
            any_done = 1'b1;
            win      = 4'(ch);
         end
      end
   end

   // ----------------------------------------------------------------------
   // Register file and bus slave
   // ----------------------------------------------------------------------
   assign accept = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'h3);

   // Read data mux, fed with the register state after any write in flight and the current channel force and busy bits
   function automatic logic [31:0] rd_mux(input logic [7:0] a, input dmars_top_t r,
                                          input logic [NCH-1:0] frc,
                                          input logic [NCH-1:0] act);
      logic [31:0] v;
      v = 32'h0;
      for (int unsigned ch = 0; ch < NCH; ch++) begin
         if (a == ch_addr(ch, OFF_REQSEL)) begin
            v[7:0]      = r.sel[ch];
            v[FORCE_BIT] = frc[ch];
         end
         if (a == ch_addr(ch, OFF_CTRL)) begin
            v[EN_BIT] = r.en[ch];
         end
      end
      if (a == OFF_LAST) begin
         v[3:0] = r.last;
      end
      if (a == OFF_BUSY) begin
         v[NCH-1:0] = act;
      end
      rd_mux = v;
   endfunction : rd_mux

   // Next state of registers and bus response
   always_comb begin
      r_d       = r_q;
      force_set = '0;
      r_d.ready = READY_RST;
      // Data phase of a write
      if (r_q.wr.valid) begin
         for (int unsigned ch = 0; ch < NCH; ch++) begin
            if (r_q.wr.addr == ch_addr(ch, OFF_REQSEL)) begin
               r_d.sel[ch]   = hwdata[7:0];
               force_set[ch] = hwdata[FORCE_BIT];      // A zero is ignored
            end
            if (r_q.wr.addr == ch_addr(ch, OFF_CTRL)) begin
               r_d.en[ch] = hwdata[EN_BIT];
            end
         end
      end
      // Status follows hardware only; writes to it fall through
      if (any_done) begin
         r_d.last = win;
      end
      // Address phase capture
      r_d.wr.valid = accept && hwrite && (hsize == HSIZE_WORD);
      r_d.wr.addr  = haddr[7:0];
      r_d.rdata    = 32'h0;
      if (accept && !hwrite) begin
         r_d.rdata = rd_mux(haddr[7:0], r_d, force_st, busy);
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r_q.sel   <= {NCH{SEL_RST}};
         r_q.en    <= '0;
         r_q.last  <= LAST_RST;
         r_q.wr    <= '{valid: 1'b0, addr: 8'h00};
         r_q.rdata <= 32'h0;
         r_q.ready <= READY_RST;
      end else begin
         r_q <= r_d;
      end
   end

   // hreadyout and hrdata come straight from flops; hresp is tied low and xfer_req decodes channel state
   assign hreadyout = r_q.ready;
   assign hresp     = 1'b0;
   assign hrdata    = r_q.rdata;
   assign xfer_req  = busy;

   // ----------------------------------------------------------------------
   // Channels
   // ----------------------------------------------------------------------
   for (genvar g = 0; g < NCH; g++) begin : g_ch
      dmars_chan u_chan (
         .clk       (clk),
         .rst_n     (rst_n),
         .enable    (r_q.en[g]),
         .force_set (force_set[g]),
         .src_sel   (r_q.sel[g]),
         .req_lines (req_lines),
         .xfer_done (xfer_done[g]),
         .force_q   (force_st[g]),
         .busy      (busy[g])
      );
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_last_write;
      accept && hwrite && haddr[7:0] == OFF_LAST ##1 !any_done;
   endsequence

   AST_LAST_RANGE: assert property (r_q.last == LAST_RST || r_q.last < 4'(NCH))
      else $error("last channel holds a reserved code");
   AST_LAST_KEEP: assert property (!any_done && r_q.last == LAST_RST |=> r_q.last == LAST_RST)
      else $error("last channel left idle code without a transfer");
   AST_LAST_UPD: assert property (any_done |=> r_q.last == $past(win) && r_q.last != LAST_RST)
      else $error("last channel not updated on completion");
   AST_LAST_RO: assert property (s_last_write |=> $stable(r_q.last))
      else $error("software write changed last channel");
   AST_READ_LAST: assert property (accept && !hwrite && haddr[7:0] == OFF_LAST
                                   |=> hrdata == {28'h0, r_q.last})
      else $error("last channel read mismatch");

   // Per channel: a select write lands, and a force write reaches an enabled channel
   for (genvar c = 0; c < NCH; c++) begin : g_chk
      sequence s_sel_write;
         r_q.wr.valid && r_q.wr.addr == ch_addr(c, OFF_REQSEL);
      endsequence

      AST_SEL_WRITE: assert property (s_sel_write |=> r_q.sel[c] == $past(hwdata[7:0]))
         else $error("request select write lost");
      AST_FORCE_WRITE: assert property (s_sel_write and (hwdata[FORCE_BIT] && r_q.en[c])
                                        |=> force_st[c])
         else $error("force write did not reach channel");
   end

endmodule : dmars_top

// >>> verif/dmars_xfer_model.sv
// Transfer engine model standing behind the request select block.
// Assumes xfer_req is a level held until this model sends a one-cycle done pulse.
`timescale 1ns/1ps

module dmars_xfer_model import dmars_pkg::*; (
   input  wire logic           clk,
   input  wire logic           rst_n,
   input  wire logic [7:0]     lat,
   input  wire logic [NCH-1:0] xfer_req,
   output logic      [NCH-1:0] xfer_done
);
   logic [NCH-1:0][7:0] cnt_q;

   // Answer each held request after lat+1 cycles with one done pulse
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q     <= '0;
         xfer_done <= '0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            xfer_done[i] <= 1'b0;
            if (xfer_req[i] && !xfer_done[i]) begin
               if (cnt_q[i] == lat) begin
                  xfer_done[i] <= 1'b1;
                  cnt_q[i]     <= 8'h00;
               end else begin
                  cnt_q[i] <= cnt_q[i] + 8'h01;
               end
            end
         end
      end
   end
endmodule : dmars_xfer_model

// >>> verif/dmars_top_tb.sv
// Self-checking bench for the request select and last-channel status block.
// Assumes the AHB-Lite slave is the only one, so hready follows hreadyout.
`timescale 1ns/1ps

module dmars_top_tb import dmars_pkg::*;;
   logic            clk, resetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0]     haddr, hwdata, hrdata, got;
   logic [1:0]      htrans;
   logic [2:0]      hsize;
   logic [NREQ-1:0] req_lines;
   logic [NCH-1:0]  xfer_done, xfer_req, req_d;
   logic [7:0]      lat;
   logic [15:0]     rnd;
   logic [31:0]     exp_q[$];
   int              rise_cnt[NCH];
   int              error_cnt, n_compared;
   event            rd_ev;

   dmars_top u_dmars_top (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .req_lines(req_lines),
      .xfer_done(xfer_done), .xfer_req(xfer_req));

   dmars_xfer_model u_dmars_xfer_model (.clk(clk), .rst_n(resetn), .lat(lat),
      .xfer_req(xfer_req), .xfer_done(xfer_done));

   // ----
   // Clock, transfer counting and read checking
   // ----
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk) begin
      req_d <= xfer_req;
      for (int i = 0; i < NCH; i++) if (xfer_req[i] === 1'b1 && req_d[i] === 1'b0) rise_cnt[i]++;
   end

   initial forever begin
      @(rd_ev);
      chk(got, exp_q.pop_front());
   end

   // ----
   // Tasks
   // ----
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   task automatic print_verdict();
      if (exp_q.size() != 0) error_cnt++;
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   task automatic ran_out();
      error_cnt++;
      $display("ERROR at %0t: wait ran out", $time);
      print_verdict();
   endtask : ran_out

   // One single word transfer; address phase held until hready, then data phase
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      hsel   <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      haddr  <= {24'h000000, a};
      hsize  <= HSIZE_WORD;
      do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 64);
      htrans <= 2'h0;
      hwdata <= d;
      do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 64);
      got = hrdata;
      chk({31'h0, hresp}, 32'h00000000);
      if (n >= 64) ran_out();
      if (!w) -> rd_ev;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 32'h00000000);
   endtask : rd

   // Wait until a channel has made its tgt-th transfer and gone idle again
   task automatic wait_xfer(input int ch, input int tgt);
      int n;
      n = 0;
      do begin @(posedge clk); n++; end
      while (!(rise_cnt[ch] == tgt && xfer_req[ch] === 1'b0) && n < 200);
      if (n >= 200) ran_out();
   endtask : wait_xfer

   // ----
   // Main sequence
   // ----
   initial begin
      resetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0;
      hsize = 3'h0; hwdata = '0; req_lines = '0; lat = 8'h00;
      rnd = 16'h9bc5;  // Seed 39877
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      rd(8'h20, 32'h0000000f);
      rd(8'h00, 32'h00000000);
      rd(8'h24, 32'h00000000);
      rd(8'h30, 32'h00000000);
      $display("reset values test done");
      wr(8'h00, 32'h0000801b);
      rd(8'h00, 32'h0000001b);
      chk(rise_cnt[0], 0);
      $display("disabled force test done");
      lat <= 8'h14;
      wr(8'h0c, 32'h00000001);
      wr(8'h08, 32'h00008000);
      wr(8'h08, 32'h00000000);
      rd(8'h08, 32'h00008000);
      rd(8'h24, 32'h00000002);
      wait_xfer(1, 1);
      rd(8'h08, 32'h00000000);
      rd(8'h20, 32'h00000001);
      chk(rise_cnt[1], 1);
      wr(8'h0c, 32'h00000000);
      $display("manual force test done");
      lat <= 8'h03;
      wr(8'h14, 32'h00000001);
      wr(8'h10, 32'h0000001b);
      req_lines[8'h1b] <= 1'b1;
      wait_xfer(2, 1);
      req_lines[8'h1b] <= 1'b0;
      wr(8'h20, 32'h00000000);
      rd(8'h20, 32'h00000002);
      wr(8'h14, 32'h00000000);
      $display("auto request test done");
      wr(8'h1c, 32'h00000001);
      for (int k = 1; k <= 3; k++) begin
         rnd = lfsr(rnd);
         wr(8'h18, {24'h000000, rnd[7:0]});
         req_lines[rnd[7:0]] <= 1'b1;
         wait_xfer(3, k);
         req_lines[rnd[7:0]] <= 1'b0;
         rd(8'h20, 32'h00000003);
      end
      chk(rise_cnt[1], 1);
      $display("random select test done");
      // Reset again in mid-run: last channel must fall back to its idle code
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      rd(8'h20, 32'h0000000f);
      rd(8'h24, 32'h00000000);
      $display("mid-run reset test done");
      @(posedge clk);
      print_verdict();
   end
endmodule : dmars_top_tb
